// >>> sim/apw_chk.sv
// port-level assertions for the angle pwm output block
// assumes apw_core top ports only, one clock, sync reset high
`timescale 1ns/1ps
module apw_chk (
    input wire logic clk_i, // clock
    input wire logic rst_i, // sync reset
    input wire logic wb_cyc_i, // cycle
    input wire logic wb_stb_i, // strobe
    input wire logic [31:0] wb_dat_o, // read data
    input wire logic wb_ack_o, // ack
    input wire logic pwm_out_o, // pin data
    input wire logic pwm_oe_o // pin enable
);
    // ==========================================================
    // run lengths of released and pulled-low pin
    logic [17:0] hi_run;
    logic [17:0] lo_run;
    always_ff @(posedge clk_i) begin
        hi_run <= (rst_i || pwm_oe_o) ? 18'h0 : hi_run + 18'h1;
    end
    always_ff @(posedge clk_i) begin
        lo_run <= (rst_i || !pwm_oe_o) ? 18'h0 : lo_run + 18'h1;
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // ==========================================================
    // assertions
    a_pin_data_low: assert property (pwm_out_o == 1'b0)
        else $error("pin data not low");
    a_high_head: assert property ($rose(pwm_oe_o) |-> hi_run >= 18'hA0)
        else $error("high part shorter than 5 percent");
    a_low_tail: assert property ($fell(pwm_oe_o) |-> lo_run >= 18'hA0)
        else $error("low part shorter than 5 percent");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not answered next cycle");
    a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    a_data_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data outside ack");
    a_reset_quiet: assert property (disable iff (1'b0) rst_i |=> !pwm_oe_o && !wb_ack_o)
        else $error("outputs active after reset edge");
endmodule : apw_chk

bind apw_core apw_chk i_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .pwm_out_o(pwm_out_o), .pwm_oe_o(pwm_oe_o));

// >>> sim/apw_core_tb.sv
// self-checking bench for apw_core over wishbone and the pwm line
// assumes apw_host as line partner and the bound checker
`timescale 1ns/1ps
`include "apw_defs.svh"
module apw_core_tb;
    logic clk_i;
    logic rst_i;
    logic req;
    logic we;
    logic [7:0] adr;
    logic [31:0] dat;
    logic [31:0] q;
    logic [8:0] cfg;
    logic [12:0] een;
    logic [11:0] ang;
    logic [13:0] flt;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic pwm_out_o;
    logic pwm_oe_o;
    logic rdy;
    logic [17:0] per;
    logic [17:0] hi;
    int err_count = 0;
    int tests_run = 0;
    int n;
    int m;
    logic [11:0] fang [2] = '{12'hFFF, 12'h800};
    logic [8:0] fcfg [3] = '{9'h0F8, 9'h082, 9'h080};
    int fhz [4] = '{3125, 2797, 2273, 3125};
    wire pin = (pwm_oe_o === 1'b1) ? 1'b0 : 1'b1;
    apw_core i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(dat),
        .wb_sel_i(4'hF), .wb_we_i(we), .wb_cyc_i(req), .wb_stb_i(req),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .output_config_row_i(cfg),
        .error_enable_row_i(een), .angle_i(ang), .watchdog_fault_i(flt[0]),
        .nvm_uncorrectable_fault_i(flt[1]), .selftest_fault_i(flt[2]),
        .pll_unlocked_fault_i(flt[3]), .zero_cross_integrity_fault_i(flt[4]),
        .averaging_fault_i(flt[5]), .analog_supply_low_i(flt[6]),
        .main_supply_low_i(flt[7]), .field_too_weak_i(flt[8]),
        .nvm_corrected_fault_i(flt[9]), .saturation_warning_i(flt[10]),
        .field_too_strong_i(flt[11]), .temperature_range_fault_i(flt[12]),
        .control_cleared_fault_i(flt[13]), .pwm_out_o(pwm_out_o), .pwm_oe_o(pwm_oe_o));
    apw_host i_host (.clk_i(clk_i), .pin_i(pin), .rdy_o(rdy), .per_o(per), .hi_o(hi));
    // ==========================================================
    // tasks
    task automatic close_out();
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : close_out
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask : chk
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
        req <= 1'b1;
        adr <= a;
        we <= w;
        dat <= d;
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1) @(posedge clk_i);
        q = wb_dat_o;
        req <= 1'b0;
        @(posedge clk_i);
    endtask : xfer
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        xfer(a, 1'b0, 32'h0);
        chk(q, e);
    endtask : rd
    task automatic rep();
        @(posedge clk_i);
        while (rdy !== 1'b1) @(posedge clk_i);
    endtask : rep
    task automatic meas(input int p, input int h);
        rep();
        rep();
        chk({14'h0, per}, p);
        chk({14'h0, hi}, h);
    endtask : meas
    function automatic int thr(input int p, input int a);
        return (p * 4096 + p * 18 * a) / 81920;
    endfunction : thr
    // ==========================================================
    // clock, watchdog, tests
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    initial begin
        repeat (105000) @(posedge clk_i);
        err_count++;
        close_out();
    end
    initial begin
        rst_i = 1'b1;
        {req, we, adr, dat, ang, flt} = '0;
        cfg = 9'h080;
        een = 13'h1FFF;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(`APW_OFS_OUTCFG, 32'h80);
        rd(`APW_OFS_ERREN, 32'h1FFF);
        rd(`APW_OFS_CTRL, 32'h0);
        xfer(8'h10, 1'b1, 32'h5A);
        rd(8'h10, 32'h0);
        meas(3200, 160);
        // each report shows the angle that stood before the last change
        m = 0;
        foreach (fang[i]) begin
            ang <= fang[i];
            rep();
            chk({14'h0, hi}, thr(3200, m));
            chk({14'h0, per}, 3200);
            m = fang[i];
        end
        // each report shows the setting written one period earlier
        foreach (fhz[i]) begin
            if (i < 3) begin
                xfer(`APW_OFS_OUTCFG, 1'b1, {23'h0, fcfg[i]});
            end
            rep();
            n = int'(per) * fhz[i] - 10000000;
            chk(n <= int'(per) / 2 && n >= -int'(per) / 2, 1'b1);
            chk({14'h0, hi}, thr(per, 2048));
        end
        flt[12] <= 1'b1;
        xfer(`APW_OFS_OUTCFG, 1'b1, 32'h100);
        meas(3200, 1600);
        flt[3] <= 1'b1;
        xfer(`APW_OFS_OUTCFG, 1'b1, 32'h180);
        meas(6400, 1400);
        rd(`APW_OFS_STATUS, 32'h80030808);
        xfer(`APW_OFS_ERREN, 1'b1, 32'h1FF7);
        meas(6400, 4280);
        flt[12] <= 1'b0;
        flt[10] <= 1'b1;
        xfer(`APW_OFS_OUTCFG, 1'b1, 32'h080);
        rep();
        n = 0;
        // stop short of the boundary so the next setup is taken there
        repeat (3150) begin
            @(posedge clk_i);
            n += (pin !== 1'b1);
        end
        chk(n, 0);
        flt[10] <= 1'b0;
        xfer(`APW_OFS_OUTCFG, 1'b1, 32'h180);
        flt[13] <= 1'b1;
        @(posedge clk_i);
        flt[13] <= 1'b0;
        meas(6400, 4640);
        xfer(`APW_OFS_CTRL, 1'b1, 32'h1);
        meas(3200, 1600);
        flt[0] <= 1'b1;
        @(posedge clk_i);
        flt[0] <= 1'b0;
        meas(6400, 320);
        rd(`APW_OFS_STATUS, 32'h80000009);
        close_out();
    end
endmodule : apw_core_tb

// >>> sim/apw_host.sv
// host model measuring period and high time of the pwm line
// assumes the line level with pull-up is resolved by the bench
`timescale 1ns/1ps
module apw_host (
    input wire logic clk_i, // clock
    input wire logic pin_i, // line level
    output logic rdy_o, // one-cycle report at rising edge
    output logic [17:0] per_o, // cycles between rising edges
    output logic [17:0] hi_o // high cycles in that period
);
    logic pin_q = 1'b1;
    logic [17:0] cnt = 18'h0;
    logic [17:0] hcnt = 18'h0;
    always_ff @(posedge clk_i) begin
        pin_q <= pin_i;
        rdy_o <= pin_i && !pin_q;
        if (pin_i && !pin_q) begin
            per_o <= cnt;
            hi_o <= hcnt;
            cnt <= 18'h1;
            hcnt <= 18'h1;
        end else begin
            cnt <= cnt + 18'h1;
            hcnt <= hcnt + {17'h0, pin_i === 1'b1};
        end
    end
endmodule : apw_host

// >>> verilog/apw_core.sv
// angle pwm output with prioritized error codes, wishbone slave
// assumes one 10 MHz clock, sync reset, fault inputs on the same clock
//
// What this block does
// - output is open drain: pull low actively, release for the high level.
// - duty stays between 5% for zero and 95% for a full turn.
// - high first 5%, low last 5%, falling edge linear in the middle 90%.
// - angle for a period is captured at its start, the rising edge.
// - duty output carries a 12-bit angle, never full scale.
// - largest high time is 5% plus 90% times 4095/4096 of the period.
// - carrier set by 3-bit range and 4-bit step, 128 choices.
// - each range and step maps to its frequency, 3125 Hz down to 98 Hz.
// - error output enable 0 ignores errors; 1 lets style select decide.
// - style 0 releases the output while a reportable error exists.
// - style 1 halves the carrier and shows the top error's duty code.
// - an error is reportable only when its own enable bit is set.
// - thirteen ranked errors, codes 5% up in 5.625% steps to 72.5%.
// - watchdog and self-test are permanent; pll flag follows the lock.
// - averaging and corrected memory errors report for two periods then clear.
// - control-cleared fault holds until the host clears it by register.
// - undervoltage reported only for unmasked supplies, while one remains.
// - weak field, saturation, strong field, temperature follow their cause.
// - internal angle refreshes every 2 us, apart from the carrier.
// - power-up loads shadow config from memory and serial regs to defaults.
`timescale 1ns/1ps
`include "apw_defs.svh"

module apw_core
    import apw_pkg::*;
(
    input wire logic clk_i,                     // 10 MHz clock
    input wire logic rst_i,                     // sync reset, high
    input wire logic [7:0] wb_adr_i,            // byte address
    input wire logic [31:0] wb_dat_i,           // write data
    input wire logic [3:0] wb_sel_i,            // byte enables
    input wire logic wb_we_i,                   // write
    input wire logic wb_cyc_i,                  // cycle
    input wire logic wb_stb_i,                  // strobe
    output logic [31:0] wb_dat_o,               // read data
    output logic wb_ack_o,                      // ack
    input wire logic [8:0] output_config_row_i, // memory shadow row
    input wire logic [12:0] error_enable_row_i, // memory shadow row
    input wire logic [11:0] angle_i,            // processed angle
    input wire logic watchdog_fault_i,          // event, sticky
    input wire logic nvm_uncorrectable_fault_i, // event, sticky
    input wire logic selftest_fault_i,          // event, sticky
    input wire logic pll_unlocked_fault_i,      // level
    input wire logic zero_cross_integrity_fault_i, // level
    input wire logic averaging_fault_i,         // event
    input wire logic analog_supply_low_i,       // level
    input wire logic main_supply_low_i,         // level
    input wire logic field_too_weak_i,          // level
    input wire logic nvm_corrected_fault_i,     // event
    input wire logic saturation_warning_i,      // level
    input wire logic field_too_strong_i,        // level
    input wire logic temperature_range_fault_i, // level
    input wire logic control_cleared_fault_i,   // event
    output logic pwm_out_o,                     // pin level, always 0
    output logic pwm_oe_o                       // high pulls pin low
);

    // ==========================================================
    // first set bit, highest priority first
    function automatic logic [3:0] top_err(input logic [12:0] v);
        logic [3:0] r;
        r = 4'hF;
        for (int i = `APW_NERR - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = 4'(i);
            end
        end
        return r;
    endfunction : top_err

    // ==========================================================
    // registers
    logic [8:0] out_cfg;
    logic [12:0] err_en;
    logic mask_an;
    logic mask_main;
    logic clr_cc;
    logic [11:0] ang_now;
    logic [4:0] upd_cnt;
    logic [`APW_CNT_W-1:0] cnt;
    logic [`APW_CNT_W-1:0] per;
    logic [`APW_CNT_W-1:0] thr;
    apw_mode_t mode;
    logic [3:0] shown_idx;
    logic [12:0] err_at;
    logic [12:0] rep_at;
    logic [11:0] ang_at;
    logic started;
    logic wd_s;
    logic nu_s;
    logic st_s;
    logic av_s;
    logic nc_s;
    logic cc_s;

    // ==========================================================
    // wishbone slave
    logic acc;
    logic [31:0] wmask;
    logic [31:0] rd;
    assign acc = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                    {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            wb_ack_o <= acc;
            wb_dat_o <= (acc && !wb_we_i) ? rd : 32'h0;
        end
    end

    always_comb begin
        rd = 32'h0;
        case (wb_adr_i)
            `APW_OFS_OUTCFG: rd[8:0] = out_cfg;
            `APW_OFS_ERREN: rd[12:0] = err_en;
            `APW_OFS_CTRL: rd[2:1] = {mask_main, mask_an};
            `APW_OFS_STATUS: begin
                rd[12:0] = err_at;
                rd[19:16] = shown_idx;
                rd[31:20] = ang_at;
            end
            default: rd = 32'h0;
        endcase
    end

    logic wr;
    logic [31:0] wv_cfg;
    logic [31:0] wv_en;
    logic [31:0] wv_ctl;
    // write lands at the edge where the master sees ack high
    assign wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
    assign wv_cfg = ({23'h0, out_cfg} & ~wmask) | (wb_dat_i & wmask);
    assign wv_en = ({19'h0, err_en} & ~wmask) | (wb_dat_i & wmask);
    assign wv_ctl = ({29'h0, mask_main, mask_an, 1'b0} & ~wmask)
                  | (wb_dat_i & wmask);

    // shadow config loads from memory rows at reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            out_cfg <= output_config_row_i;
            err_en <= error_enable_row_i;
        end else if (wr && wb_adr_i == `APW_OFS_OUTCFG) begin
            out_cfg <= wv_cfg[8:0];
        end else if (wr && wb_adr_i == `APW_OFS_ERREN) begin
            err_en <= wv_en[12:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            {mask_main, mask_an, clr_cc} <= `APW_CTRL_RST;
        end else begin
            clr_cc <= wr && wb_adr_i == `APW_OFS_CTRL
                   && wv_ctl[`APW_F_CLR_CC];
            if (wr && wb_adr_i == `APW_OFS_CTRL) begin
                mask_an <= wv_ctl[`APW_F_MASK_AN];
                mask_main <= wv_ctl[`APW_F_MASK_MAIN];
            end
        end
    end

    // ==========================================================
    // internal angle refresh
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            upd_cnt <= 5'h0;
            ang_now <= 12'h0;
        end else if (upd_cnt == 5'(`APW_ANG_UPD_CYC - 1)) begin
            upd_cnt <= 5'h0;
            ang_now <= angle_i;
        end else begin
            upd_cnt <= upd_cnt + 5'h1;
        end
    end

    // ==========================================================
    // error sources
    logic start;
    logic [12:0] once_clr;
    logic [12:0] err;
    logic [12:0] rep;
    assign start = !started || cnt == per - `APW_CNT_W'(1);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            {wd_s, nu_s, st_s, av_s, nc_s, cc_s} <= 6'h0;
        end else begin
            wd_s <= wd_s | watchdog_fault_i;
            nu_s <= nu_s | nvm_uncorrectable_fault_i;
            st_s <= st_s | selftest_fault_i;
            av_s <= averaging_fault_i
                 | (av_s & !once_clr[APW_E_AVERAGING]);
            nc_s <= nvm_corrected_fault_i
                 | (nc_s & !once_clr[APW_E_NVM_CORR]);
            cc_s <= control_cleared_fault_i | (cc_s & !clr_cc);
        end
    end

    always_comb begin
        err = 13'h0;
        err[APW_E_WATCHDOG] = wd_s;
        err[APW_E_NVM_UNCORR] = nu_s;
        err[APW_E_SELFTEST] = st_s;
        err[APW_E_PLL] = pll_unlocked_fault_i;
        err[APW_E_ZERO_CROSS] = zero_cross_integrity_fault_i;
        err[APW_E_AVERAGING] = av_s;
        err[APW_E_SUPPLY_LOW] = (analog_supply_low_i & !mask_an)
                              | (main_supply_low_i & !mask_main);
        err[APW_E_FIELD_WEAK] = field_too_weak_i;
        err[APW_E_NVM_CORR] = nc_s;
        err[APW_E_SATURATION] = saturation_warning_i;
        err[APW_E_FIELD_STRONG] = field_too_strong_i;
        err[APW_E_TEMPERATURE] = temperature_range_fault_i;
        err[APW_E_CTRL_CLEARED] = cc_s;
    end

    assign rep = err & err_en;

    // one-shot bits clear once shown, or if never reportable
    for (genvar g = 0; g < `APW_NERR; g++) begin : g_once
        assign once_clr[g] = start && started && err_at[g]
            && (!rep_at[g] || mode == APW_MODE_RELEASE
                || (mode == APW_MODE_CODE && shown_idx == 4'(g)));
    end

    // ==========================================================
    // next period setup
    logic [2:0] rng;
    logic [3:0] stp;
    logic [12:0] idx_n;
    logic [`APW_CNT_W-1:0] base_per;
    apw_mode_t next_mode;
    logic [`APW_CNT_W-1:0] next_per;
    logic [3:0] next_idx;
    logic [35:0] prod;
    logic [`APW_CNT_W-1:0] next_thr;

    assign rng = out_cfg[`APW_F_RANGE_LO +: 3];
    assign stp = out_cfg[`APW_F_STEP_LO +: 4];
    assign idx_n = 13'(`APW_IDX_BASE) + (13'(`APW_IDX_BAND) << rng)
                 + (13'(stp) << rng);
    assign base_per = `APW_CNT_W'(idx_n) * `APW_CNT_W'(`APW_UNIT_CYC);
    assign next_idx = top_err(rep);

    always_comb begin
        next_mode = APW_MODE_ANGLE;
        if (out_cfg[`APW_F_EOE] && rep != 13'h0) begin
            next_mode = out_cfg[`APW_F_ESS] ? APW_MODE_CODE
                                             : APW_MODE_RELEASE;
        end
    end

    assign next_per = (next_mode == APW_MODE_CODE)
                    ? {base_per[`APW_CNT_W-2:0], 1'b0} : base_per;

    always_comb begin
        if (next_mode == APW_MODE_CODE) begin
            prod = 36'(next_per) * (36'(`APW_ERR_OFS)
                 + 36'(`APW_ERR_MUL) * 36'(next_idx));
            next_thr = `APW_CNT_W'(prod / 36'(`APW_ERR_DEN));
        end else begin
            prod = 36'(next_per) * (36'(`APW_ANG_OFS)
                 + 36'(`APW_ANG_MUL) * 36'(ang_now));
            next_thr = `APW_CNT_W'(prod / 36'(`APW_ANG_DEN));
        end
    end

    // ==========================================================
    // period counter, latched state per period
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            started <= 1'b0;
            cnt <= `APW_CNT_W'(0);
            per <= `APW_CNT_W'(1);
            thr <= `APW_CNT_W'(0);
            mode <= APW_MODE_ANGLE;
            shown_idx <= 4'hF;
            err_at <= 13'h0;
            rep_at <= 13'h0;
            ang_at <= 12'h0;
        end else if (start) begin
            started <= 1'b1;
            cnt <= `APW_CNT_W'(0);
            per <= next_per;
            thr <= next_thr;
            mode <= next_mode;
            shown_idx <= next_idx;
            err_at <= err;
            rep_at <= rep;
            ang_at <= ang_now;
        end else begin
            cnt <= cnt + `APW_CNT_W'(1);
        end
    end

    // ==========================================================
    // open-drain pin: release while high, pull during low part
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pwm_out_o <= 1'b0;
            pwm_oe_o <= 1'b0;
        end else begin
            pwm_out_o <= 1'b0;
            pwm_oe_o <= started && mode != APW_MODE_RELEASE
                     && cnt >= thr;
        end
    end

endmodule : apw_core

// >>> verilog/apw_defs.svh
// register offsets, field positions, reset values and timing counts
// assumes a 10 MHz system clock and a word-aligned wishbone bus
`ifndef APW_DEFS_SVH
`define APW_DEFS_SVH

// ==========================================================
// timing
`define APW_CLK_NS 100
`define APW_ANG_UPD_NS 2000
`define APW_ANG_UPD_CYC ((`APW_ANG_UPD_NS + `APW_CLK_NS - 1) / `APW_CLK_NS)
`define APW_UNIT_NS 2500
`define APW_UNIT_CYC (`APW_UNIT_NS / `APW_CLK_NS)

// ==========================================================
// carrier period index: base 112 + (16 << range) + (step << range)
`define APW_IDX_BASE 112
`define APW_IDX_BAND 16

// ==========================================================
// duty fractions: angle 4096/81920 + 18*a/81920, code (8+9k)/160
`define APW_ANG_OFS 4096
`define APW_ANG_MUL 18
`define APW_ANG_DEN 81920
`define APW_ERR_OFS 8
`define APW_ERR_MUL 9
`define APW_ERR_DEN 160

// ==========================================================
// register map (byte addresses)
`define APW_OFS_OUTCFG 8'h00
`define APW_OFS_ERREN 8'h04
`define APW_OFS_CTRL 8'h08
`define APW_OFS_STATUS 8'h0C

// ==========================================================
// field positions
`define APW_F_RANGE_LO 0
`define APW_F_STEP_LO 3
`define APW_F_EOE 7
`define APW_F_ESS 8
`define APW_F_CLR_CC 0
`define APW_F_MASK_AN 1
`define APW_F_MASK_MAIN 2
`define APW_F_ST_REP 20
`define APW_F_ST_IDX 16
`define APW_F_ST_ANG 20

// ==========================================================
// widths and reset values
`define APW_NERR 13
`define APW_CNT_W 18
`define APW_CTRL_RST 3'h0

`endif

// >>> verilog/apw_pkg.sv
// types shared by the angle pwm output block
// assumes apw_defs.svh is on the include path
package apw_pkg;

    // ==========================================================
    // output behaviour of one carrier period
    typedef enum logic [1:0] {
        APW_MODE_ANGLE,
        APW_MODE_CODE,
        APW_MODE_RELEASE
    } apw_mode_t;

    // errors in falling priority order, index = bit position
    typedef enum logic [3:0] {
        APW_E_WATCHDOG,
        APW_E_NVM_UNCORR,
        APW_E_SELFTEST,
        APW_E_PLL,
        APW_E_ZERO_CROSS,
        APW_E_AVERAGING,
        APW_E_SUPPLY_LOW,
        APW_E_FIELD_WEAK,
        APW_E_NVM_CORR,
        APW_E_SATURATION,
        APW_E_FIELD_STRONG,
        APW_E_TEMPERATURE,
        APW_E_CTRL_CLEARED
    } apw_err_t;

endpackage : apw_pkg
